// File: pvsw_core.sv
// PV input conditioning, switching, contact decode and output selection
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// R1: method register picks band, limit or contact
// R2: upper and lower switching limits are registers
// R3: rising band: transfer from lower to upper
// R4: falling band: transfer back from upper to lower
// R5: inside band, linear weighted mix, no step
// R6: limit mode: input two at/above upper
// R7: limit hysteresis is 0.5% of range
// R8: MV bumpless when selected input changes
// R9: contact mode: seventh contact picks input
// R10: contacts one to four decode group number
// R11: all four off keeps last group
// R12: unlisted contact patterns keep last group
// R13: fifth contact on gives automatic mode
// R14: manual mode: up/down keys move MV
// R15: sixth contact on stops, preset output driven
// R16: stop overrides manual output
// R17: stopped still acquires and conditions inputs
// R18: input one bias, root, linearizer, lag
// R19: input two gets the same conditioning
// R20: eleven-point tables, mode picks approx/bias
// R21: lag then bias after the selection
// R22: operating bias/filter act in normal operation
// R23: eight groups, key or contact selects
// R24: setpoint and preset follow selected group
module pvsw_core
  import pvsw_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire pvsw_sample_t   sample,
  input  wire logic           sample_valid,
  input  wire pvsw_contacts_t contacts,
  input  wire pvsw_val_t      mv_computed,
  input  wire logic           key_up,
  input  wire logic           key_down,
  output pvsw_val_t           pv,
  output pvsw_val_t           active_setpoint,
  output pvsw_val_t           active_preset,
  output pvsw_val_t           mv,
  output logic      [2:0]     setpoint_group_number,
  output logic                auto_mode,
  output logic                running,
  output logic                input_two_in_use
);

  ////////////////////////////////////////
  // Arithmetic helpers

  function automatic pvsw_val_t sat(input longint v);
    if (v > 32767) sat = 16'h7fff;
    else if (v < -32768) sat = 16'h8000;
    else sat = pvsw_val_t'(v[15:0]);
  endfunction

  // Root of a 0..full-scale value, rescaled to full scale
  function automatic pvsw_val_t root(input pvsw_val_t x);
    logic [31:0] v;
    logic [15:0] r;
    logic [15:0] t;
    v = {2'h0, x[14:0], 15'h0000};
    r = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      t = r | (16'h0001 << i);
      if ({16'h0000, t} * {16'h0000, t} <= v) r = t;
    end
    root = x[15] ? RST_ZERO : pvsw_val_t'(r);
  endfunction

  // First-order lag; a shift of zero passes the input through
  function automatic pvsw_val_t lag(input pvsw_val_t y, input pvsw_val_t x,
                                    input logic [3:0] s);
    longint d;
    d = longint'(x) - longint'(y);
    lag = sat(longint'(y) + (d >>> s));
  endfunction

  // Ten-segment linearizer, approximation or biasing
  function automatic pvsw_val_t linearize(input pvsw_val_t x, input pvsw_tab_t a,
                                          input pvsw_tab_t b, input logic bias_mode);
    int     seg;
    longint px;
    longint dx;
    longint y;
    seg = 0;
    for (int i = 1; i < LIN_PTS - 1; i++) begin
      if (x >= a[i]) seg = i;
    end
    px = longint'(x);
    if (px < longint'(a[0])) px = longint'(a[0]);
    if (px > longint'(a[LIN_PTS-1])) px = longint'(a[LIN_PTS-1]);
    dx = longint'(a[seg+1]) - longint'(a[seg]);
    y  = longint'(b[seg]);
    if (dx > 0) begin
      y = y + ((px - longint'(a[seg])) * (longint'(b[seg+1]) - longint'(b[seg]))) / dx;
    end
    linearize = bias_mode ? sat(longint'(x) + y) : sat(y);
  endfunction

  // Full conditioning chain of one channel before the lag
  function automatic pvsw_val_t condition(input pvsw_val_t x, input pvsw_val_t bias,
                                          input logic sq, input logic len,
                                          input logic lmode, input pvsw_tab_t a,
                                          input pvsw_tab_t b);
    pvsw_val_t v;
    v = sat(longint'(x) + longint'(bias));
    if (sq) v = root(v);
    if (len) v = linearize(v, a, b, lmode);
    condition = v;
  endfunction

  // Group decode of contacts one to four; bit 3 flags a listed pattern
  function automatic logic [3:0] decode_group(input pvsw_contacts_t c);
    unique case ({c.contact_in_4, c.contact_in_3, c.contact_in_2, c.contact_in_1})
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        decode_group = {1'b1, 3'({c.contact_in_3, c.contact_in_2, c.contact_in_1}) - 3'h1};
      end
      4'h8: decode_group = 4'hf;
      default: decode_group = 4'h0; // see R11 see R12
    endcase
  endfunction

  ////////////////////////////////////////
  // Register storage

  logic      [8:0] ctrl;
  pvsw_val_t       upper;
  pvsw_val_t       lower;
  pvsw_val_t       pv_range;
  pvsw_val_t       bias1;
  pvsw_val_t       bias2;
  pvsw_val_t       op_bias;
  logic      [3:0] filt1;
  logic      [3:0] filt2;
  logic      [3:0] op_filt;
  pvsw_val_t       step;
  pvsw_val_t       sp_tab [8];
  pvsw_val_t       po_tab [8];
  pvsw_tab_t       lin_tab [4];

  logic        wr_go;
  logic        hit;
  logic [31:0] rd_word;
  logic [5:0]  lin_idx;
  logic [1:0]  lin_t;
  logic [3:0]  lin_i;
  logic [2:0]  grp_i;

  assign wr_go   = psel & penable & pready & pwrite;
  assign lin_idx = 6'((paddr - LIN_BASE) >> 2);
  assign lin_t   = 2'(lin_idx / 6'd11);
  assign lin_i   = 4'(lin_idx % 6'd11);
  assign grp_i   = paddr[4:2];

  // Address decode and read data
  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    if (paddr[1:0] != 2'h0) hit = 1'b0;
    else if (paddr >= LIN_BASE && paddr < LIN_END) rd_word = 32'(lin_tab[lin_t][lin_i]);
    else if (paddr >= PO_BASE && paddr < LIN_BASE) rd_word = 32'(po_tab[grp_i]);
    else if (paddr >= SP_BASE && paddr < PO_BASE) rd_word = 32'(sp_tab[grp_i]);
    else begin
      unique case (paddr)
        CTRL_OFS:   rd_word = 32'(ctrl);
        UPPER_OFS:  rd_word = 32'(upper);
        LOWER_OFS:  rd_word = 32'(lower);
        RANGE_OFS:  rd_word = 32'(pv_range);
        BIAS1_OFS:  rd_word = 32'(bias1);
        FILT1_OFS:  rd_word = 32'(filt1);
        BIAS2_OFS:  rd_word = 32'(bias2);
        FILT2_OFS:  rd_word = 32'(filt2);
        OPBIAS_OFS: rd_word = 32'(op_bias);
        OPFILT_OFS: rd_word = 32'(op_filt);
        STEP_OFS:   rd_word = 32'(step);
        GROUP_OFS:  rd_word = 32'(setpoint_group_number);
        STATUS_OFS: rd_word = 32'({input_two_in_use, running, auto_mode, setpoint_group_number});
        PV_OFS:     rd_word = 32'(pv);
        MV_OFS:     rd_word = 32'(mv);
        default:    hit = 1'b0;
      endcase
    end
  end

  // APB answer: one access cycle, registered data and error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata  <= (psel & ~penable & ~pwrite & hit) ? rd_word : 32'h0000_0000;
    end
  end

  // Scalar setup and operating registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= RST_CTRL;
      upper    <= RST_ZERO;
      lower    <= RST_ZERO;
      pv_range <= RST_RANGE;
      bias1    <= RST_ZERO;
      bias2    <= RST_ZERO;
      op_bias  <= RST_ZERO;
      filt1    <= 4'h0;
      filt2    <= 4'h0;
      op_filt  <= 4'h0;
      step     <= RST_STEP;
    end else if (wr_go && !pslverr) begin
      unique case (paddr)
        CTRL_OFS:   ctrl <= pwdata[8:0]; // see R1
        UPPER_OFS:  upper <= pwdata[15:0]; // see R2
        LOWER_OFS:  lower <= pwdata[15:0]; // see R2
        RANGE_OFS:  pv_range <= pwdata[15:0];
        BIAS1_OFS:  bias1 <= pwdata[15:0];
        FILT1_OFS:  filt1 <= pwdata[3:0];
        BIAS2_OFS:  bias2 <= pwdata[15:0];
        FILT2_OFS:  filt2 <= pwdata[3:0];
        OPBIAS_OFS: op_bias <= pwdata[15:0];
        OPFILT_OFS: op_filt <= pwdata[3:0];
        STEP_OFS:   step <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Group tables and linearizer tables; contents are not reset
  always_ff @(posedge pclk) begin
    if (wr_go && !pslverr) begin
      if (paddr >= LIN_BASE && paddr < LIN_END) lin_tab[lin_t][lin_i] <= pwdata[15:0]; // see R20
      else if (paddr >= PO_BASE && paddr < LIN_BASE) po_tab[grp_i] <= pwdata[15:0];
      else if (paddr >= SP_BASE && paddr < PO_BASE) sp_tab[grp_i] <= pwdata[15:0]; // see R23
    end
  end

  ////////////////////////////////////////
  // Input conditioning and switching

  pvsw_val_t f1;
  pvsw_val_t f2;
  pvsw_val_t pv_lag;
  pvsw_val_t sel_prev;
  logic      rising;
  logic      next_sel2;
  pvsw_val_t next_sel;
  pvsw_val_t pos;
  longint    num;
  longint    den;
  longint    hyst;

  // Selection between the conditioned channels
  always_comb begin
    hyst      = (longint'(pv_range) * HYST_NUM) / HYST_DEN; // see R7
    pos       = rising ? f1 : f2; // see R3 see R4
    num       = longint'(pos) - longint'(lower);
    den       = longint'(upper) - longint'(lower);
    next_sel2 = input_two_in_use;
    next_sel  = f1;
    unique case (ctrl[CTRL_METHOD +: 2])
      METHOD_BAND: begin
        next_sel2 = num >= den;
        if (num <= 0) next_sel = f1; // see R3 see R4
        else if (num >= den) next_sel = f2;
        else next_sel = sat(longint'(f1) + ((longint'(f2) - longint'(f1)) * num) / den); // see R5
      end
      METHOD_LIMIT: begin
        if (f1 >= upper) next_sel2 = 1'b1; // see R6
        else if (longint'(f1) < longint'(upper) - hyst) next_sel2 = 1'b0; // see R7
        next_sel = next_sel2 ? f2 : f1;
      end
      METHOD_CONTACT: begin
        next_sel2 = contacts.input_select_contact; // see R9
        next_sel  = next_sel2 ? f2 : f1;
      end
      default: next_sel = f1;
    endcase
  end

  // Channel chains run on every sample, stopped or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f1 <= RST_ZERO;
      f2 <= RST_ZERO;
    end else if (sample_valid) begin // see R17
      f1 <= lag(f1, condition(sample.universal_input_one, bias1, ctrl[CTRL_SQRT1],
                ctrl[CTRL_LEN1], ctrl[CTRL_LMODE1], lin_tab[0], lin_tab[1]),
                filt1); // see R18 see R22
      f2 <= lag(f2, condition(sample.voltage_input_two, bias2, ctrl[CTRL_SQRT2],
                ctrl[CTRL_LEN2], ctrl[CTRL_LMODE2], lin_tab[2], lin_tab[3]),
                filt2); // see R19 see R22
    end
  end

  // Selected value, direction, then operating lag and bias
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_prev         <= RST_ZERO;
      rising           <= 1'b1;
      input_two_in_use <= 1'b0;
      pv_lag           <= RST_ZERO;
      pv               <= RST_ZERO;
    end else if (sample_valid) begin
      sel_prev         <= next_sel;
      rising           <= next_sel >= sel_prev;
      input_two_in_use <= next_sel2;
      pv_lag           <= lag(pv_lag, next_sel, op_filt); // see R21
      pv               <= sat(longint'(lag(pv_lag, next_sel, op_filt))
                              + longint'(op_bias)); // see R21 see R22
    end
  end

  ////////////////////////////////////////
  // Contact decode and modes

  pvsw_contacts_t cprev;
  logic [3:0]     dec;

  assign dec = decode_group(contacts);

  // Contacts win over a key write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cprev                 <= '0;
      setpoint_group_number <= 3'h0;
    end else begin
      cprev <= contacts;
      if (contacts != cprev && dec[3]) setpoint_group_number <= dec[2:0]; // see R10 see R11
      else if (wr_go && !pslverr && paddr == GROUP_OFS) begin
        setpoint_group_number <= pwdata[2:0]; // see R23
      end
    end
  end

  // Group parameters for the downstream stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_setpoint <= RST_ZERO;
      active_preset   <= RST_ZERO;
    end else begin
      active_setpoint <= sp_tab[setpoint_group_number]; // see R24
      active_preset   <= po_tab[setpoint_group_number]; // see R24
    end
  end

  // Mode flags follow the contacts and the stop key bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_mode <= 1'b0;
      running   <= 1'b0;
    end else begin
      auto_mode <= contacts.auto_manual_contact; // see R13
      running   <= ~contacts.run_stop_contact & ~ctrl[CTRL_STOP]; // see R15
    end
  end

  ////////////////////////////////////////
  // Manipulated output

  pvsw_val_t manual_mv;
  pvsw_val_t bump;
  pvsw_val_t next_mv;
  logic      switched;

  assign switched = sample_valid && next_sel2 != input_two_in_use
                    && ctrl[CTRL_METHOD +: 2] != METHOD_BAND;

  // Stop beats manual, manual beats automatic
  always_comb begin
    if (!running) next_mv = active_preset; // see R15 see R16
    else if (!auto_mode) next_mv = manual_mv; // see R14
    else next_mv = sat(longint'(mv_computed) + longint'(bump));
    if (next_mv > MV_FULL) next_mv = MV_FULL;
    if (next_mv < RST_ZERO) next_mv = RST_ZERO;
  end

  // Offset that hides a PV step from the output, then bleeds away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bump <= RST_ZERO;
    else if (switched) bump <= sat(longint'(mv) - longint'(mv_computed)); // see R8
    else if (sample_valid) bump <= sat(longint'(bump) - longint'(bump >>> BUMP_DECAY));
  end

  // Manual value tracks the output so entering manual is smooth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) manual_mv <= RST_ZERO;
    else if (running && !auto_mode) begin
      if (key_up && !key_down) manual_mv <= sat(longint'(manual_mv) + longint'(step)); // see R14
      else if (key_down && !key_up) manual_mv <= sat(longint'(manual_mv) - longint'(step));
      if (manual_mv > MV_FULL) manual_mv <= MV_FULL;
      if (manual_mv < RST_ZERO) manual_mv <= RST_ZERO;
    end else manual_mv <= mv;
  end

  // Registered output value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mv <= RST_ZERO;
    else mv <= next_mv;
  end

endmodule

`default_nettype wire

// File: pvsw_core_assertions.sv
// Port-level assertion checker for the PV switch block
`timescale 1ns/100ps
`default_nettype none
module pvsw_core_assertions
  import pvsw_pkg::*;
(
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic           sample_valid,
  input wire pvsw_contacts_t contacts,
  input wire pvsw_val_t      pv,
  input wire pvsw_val_t      active_preset,
  input wire pvsw_val_t      mv,
  input wire logic [2:0]     setpoint_group_number,
  input wire logic           auto_mode,
  input wire logic           running,
  input wire logic           input_two_in_use
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // Group contacts as a nibble; listed means the decode table has it
  logic [3:0] dsel;
  logic       lst;
  assign dsel = contacts[3:0];
  assign lst  = (dsel != 4'h0) && (!dsel[3] || dsel == 4'h8);
  // Output clamp, so a wild preset cannot leave the span
  function automatic pvsw_val_t clip(input pvsw_val_t v);
    return (v < RST_ZERO) ? RST_ZERO : ((v > MV_FULL) ? MV_FULL : v);
  endfunction
  ////////////////////////////////////////////////////////////////
  // Held patterns give the registered decode time to settle
  sequence s_setup; psel && !penable; endsequence
  sequence s_listed; (lst && $stable(dsel)) [*3]; endsequence
  sequence s_unlisted; !lst [*3]; endsequence
  sequence s_stopped; (contacts.run_stop_contact && $stable(active_preset)) [*4]; endsequence
  property p_ready_after_setup; s_setup |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
  property p_run; $past(presetn) && $past(contacts.run_stop_contact) |-> !running; endproperty
  property p_auto; $past(presetn) |-> auto_mode == $past(contacts.auto_manual_contact);
  endproperty
  property p_stop_mv; s_stopped |-> mv == clip(active_preset); endproperty
  property p_mv_range; mv >= RST_ZERO && mv <= MV_FULL; endproperty
  property p_group_dec;
    s_listed |-> setpoint_group_number == (dsel[3] ? 3'h7 : 3'(dsel[2:0] - 3'h1));
  endproperty
  property p_group_keep; s_unlisted |-> $stable(setpoint_group_number); endproperty
  property p_pv_edges;
    $past(presetn) && !$past(sample_valid) |-> $stable(pv) && $stable(input_two_in_use);
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready late");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
  a_run: assert property (p_run) else $error("running while stop contact on");
  a_auto: assert property (p_auto) else $error("auto mode wrong");
  a_stop_mv: assert property (p_stop_mv) else $error("stopped output not preset");
  a_mv_range: assert property (p_mv_range) else $error("output out of span");
  a_group_dec: assert property (p_group_dec) else $error("group decode wrong");
  a_group_keep: assert property (p_group_keep) else $error("group not kept");
  a_pv_edges: assert property (p_pv_edges) else $error("pv moved off sample");
endmodule
bind pvsw_core pvsw_core_assertions i_pvsw_core_assertions (.pclk, .presetn, .psel, .penable,
  .prdata, .pready, .pslverr, .sample_valid, .contacts, .pv, .active_preset, .mv,
  .setpoint_group_number, .auto_mode, .running, .input_two_in_use);
`default_nettype wire

// File: pvsw_core_tb_top.sv
// Self-checking bench of the PV switch block
`timescale 1ns/100ps
`default_nettype none
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module pvsw_core_tb_top import pvsw_pkg::*;;
  logic           pclk, presetn, psel, penable, pwrite, want_go, key_up, key_down;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, rd_data, got_v, exp_v;
  logic           pready, pslverr, rd_err, auto_mode, running, input_two_in_use;
  logic [2:0]     setpoint_group_number;
  pvsw_val_t      pv, active_setpoint, active_preset, mv, mv_computed;
  pvsw_sample_t   want_sample, sample;
  pvsw_contacts_t want_contacts, contacts;
  logic           sample_valid;
  int             bad_count, cmp_count, sel_q[$];
  logic [31:0]    exp_q[$];
  event           look;
  // Limit rows then band rows: method, input one, input two, expected pv
  localparam pvsw_val_t TAB [7][4] = '{
    '{16'h0001, 16'h0064, 16'h0bb8, 16'h0064}, '{16'h0001, 16'h07cf, 16'h0bb8, 16'h07cf},
    '{16'h0001, 16'h07d0, 16'h0bb8, 16'h0bb8}, '{16'h0001, 16'h079f, 16'h0bb8, 16'h0bb8},
    '{16'h0001, 16'h079d, 16'h0bb8, 16'h079d}, '{16'h0000, 16'h01f4, 16'h0320, 16'h01f4},
    '{16'h0000, 16'h09c4, 16'h0a28, 16'h0a28}};
  ////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  pvsw_field_model i_pvsw_field_model (.pclk, .presetn, .want_go, .want_sample,
    .want_contacts, .sample, .sample_valid, .contacts);
  pvsw_core i_pvsw_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sample, .sample_valid, .contacts, .mv_computed, .key_up, .key_down,
    .pv, .active_setpoint, .active_preset, .mv, .setpoint_group_number, .auto_mode, .running,
    .input_two_in_use);
  ////////////////////////////////////////////////////////////////
  // Monitor: pairs each note with the output it names
  function automatic logic [31:0] pick(input int s);
    case (s)
      0: return {16'h0, pv};
      1: return {29'h0, setpoint_group_number};
      2: return {16'h0, mv};
      3: return {31'h0, auto_mode};
      4: return {31'h0, running};
      5: return {31'h0, input_two_in_use};
      6: return rd_data;
      8: return {16'h0, active_preset};
      9: return {16'h0, active_setpoint};
      default: return {31'h0, rd_err};
    endcase
  endfunction
  always @(look) begin
    while (sel_q.size() > 0) begin
      got_v = pick(sel_q.pop_front());
      exp_v = exp_q.pop_front();
      `CMP(got_v, exp_v)
    end
  end
  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic note(input int s, input logic [31:0] e);
    sel_q.push_back(s);
    exp_q.push_back(e);
    -> look;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // APB master: holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, 32'h0);
    note(6, e);
    note(7, {31'h0, err});
  endtask
  task automatic setc(input pvsw_contacts_t c);
    @(posedge pclk);
    want_contacts <= c;
    cyc(6);
  endtask
  task automatic press(input logic up);
    @(posedge pclk);
    key_up   <= up;
    key_down <= !up;
    @(posedge pclk);
    key_up   <= 1'b0;
    key_down <= 1'b0;
  endtask
  // Same pair twice: pv shows a sample one strobe later
  task automatic feed(input pvsw_val_t a, input pvsw_val_t b);
    repeat (2) begin
      @(posedge pclk);
      want_sample <= {a, b};
      want_go     <= 1'b1;
      @(posedge pclk);
      want_go <= 1'b0;
    end
    cyc(4);
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    pvsw_val_t a, b;
    {psel, penable, pwrite, want_go, key_up, key_down, paddr, pwdata} = '0;
    {want_sample, want_contacts, mv_computed} = '0;
    presetn = 1'b0;
    void'($urandom(39390));
    cyc(16);
    presetn <= 1'b1;
    rd(CTRL_OFS, 32'h0, 1'b0);
    rd(RANGE_OFS, 32'h2710, 1'b0);
    rd(STEP_OFS, 32'h000a, 1'b0);
    rd(12'h200, 32'h0, 1'b1);
    rd(12'h006, 32'h0, 1'b1);
    $display("test regs done");
    for (int p = 1; p <= 8; p++) begin
      setc(7'(p));
      note(1, (p == 8) ? 32'h7 : 32'(p - 1));
    end
    setc(7'h00);
    note(1, 32'h7);
    setc(7'(4'h8 | 4'($urandom_range(1, 7))));
    note(1, 32'h7);
    $display("test decode done");
    apb(1'b1, PO_BASE + 12'h008, 32'h1234);
    apb(1'b1, SP_BASE + 12'h008, 32'h0777);
    mv_computed <= 16'h01f4;
    setc(7'h13);
    note(1, 32'h2);
    note(8, 32'h1234);
    note(9, 32'h0777);
    note(3, 32'h1);
    note(4, 32'h1);
    note(2, 32'h01f4);
    mv_computed <= 16'h7fff;
    cyc(4);
    note(2, 32'h2710);
    mv_computed <= 16'h01f4;
    cyc(4);
    setc(7'h03);
    repeat (3) press(1'b1);
    press(1'b0);
    cyc(3);
    note(3, 32'h0);
    note(2, 32'h0208);
    setc(7'h23);
    press(1'b1);
    cyc(3);
    note(4, 32'h0);
    note(2, 32'h1234);
    $display("test modes done");
    apb(1'b1, CTRL_OFS, 32'h2);
    for (int i = 0; i < 6; i++) begin
      a = 16'($urandom_range(0, 16383));
      b = 16'($urandom_range(0, 16383));
      setc({i[0], 1'($urandom_range(0, 1)), 5'h10});
      feed(a, b);
      note(0, {16'h0, i[0] ? b : a});
      note(5, {31'h0, i[0]});
    end
    $display("test contact select done");
    setc(7'h10);
    apb(1'b1, UPPER_OFS, 32'h07d0);
    apb(1'b1, LOWER_OFS, 32'h03e8);
    rd(UPPER_OFS, 32'h07d0, 1'b0);
    foreach (TAB[r]) begin
      apb(1'b1, CTRL_OFS, {16'h0, TAB[r][0]});
      feed(TAB[r][1], TAB[r][2]);
      note(0, {16'h0, TAB[r][3]});
      note(5, {31'h0, TAB[r][3] == TAB[r][2]});
    end
    $display("test limit band done");
    print_verdict();
  end
endmodule
`default_nettype wire

// File: pvsw_field_model.sv
// Field side model: analog sensor samples and contact switches
`timescale 1ns/100ps
`default_nettype none
module pvsw_field_model
  import pvsw_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           want_go,
  input  wire pvsw_sample_t   want_sample,
  input  wire pvsw_contacts_t want_contacts,
  output var pvsw_sample_t    sample,
  output logic                sample_valid,
  output var pvsw_contacts_t  contacts
);
  // Contacts move only on an edge, like a debounced switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contacts <= '0;
    end else begin
      contacts <= want_contacts;
    end
  end
  // Data is real only with the strobe; it flips otherwise so stale use shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_valid <= 1'b0;
      sample       <= '0;
    end else begin
      sample_valid <= want_go;
      sample       <= want_go ? want_sample : ~sample;
    end
  end
endmodule
`default_nettype wire

// File: pvsw_pkg.sv
// Constants, register map and carriers of the PV input switch block
package pvsw_pkg;

  typedef logic signed [15:0] pvsw_val_t;
  typedef pvsw_val_t [10:0]   pvsw_tab_t;

  // Contact inputs as they arrive from the terminal block
  typedef struct packed {
    logic input_select_contact;
    logic run_stop_contact;
    logic auto_manual_contact;
    logic contact_in_4;
    logic contact_in_3;
    logic contact_in_2;
    logic contact_in_1;
  } pvsw_contacts_t;

  // One conversion result of each analog channel
  typedef struct packed {
    pvsw_val_t universal_input_one;
    pvsw_val_t voltage_input_two;
  } pvsw_sample_t;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] UPPER_OFS  = 12'h004;
  localparam logic [11:0] LOWER_OFS  = 12'h008;
  localparam logic [11:0] RANGE_OFS  = 12'h00c;
  localparam logic [11:0] BIAS1_OFS  = 12'h010;
  localparam logic [11:0] FILT1_OFS  = 12'h014;
  localparam logic [11:0] BIAS2_OFS  = 12'h018;
  localparam logic [11:0] FILT2_OFS  = 12'h01c;
  localparam logic [11:0] OPBIAS_OFS = 12'h020;
  localparam logic [11:0] OPFILT_OFS = 12'h024;
  localparam logic [11:0] STEP_OFS   = 12'h028;
  localparam logic [11:0] GROUP_OFS  = 12'h02c;
  localparam logic [11:0] STATUS_OFS = 12'h030;
  localparam logic [11:0] PV_OFS     = 12'h034;
  localparam logic [11:0] MV_OFS     = 12'h038;
  localparam logic [11:0] SP_BASE    = 12'h040;
  localparam logic [11:0] PO_BASE    = 12'h060;
  localparam logic [11:0] LIN_BASE   = 12'h080;
  localparam logic [11:0] LIN_END    = 12'h130;

  // Control register fields
  localparam int CTRL_METHOD = 0;
  localparam int CTRL_SQRT1  = 2;
  localparam int CTRL_SQRT2  = 3;
  localparam int CTRL_LMODE1 = 4;
  localparam int CTRL_LMODE2 = 5;
  localparam int CTRL_LEN1   = 6;
  localparam int CTRL_LEN2   = 7;
  localparam int CTRL_STOP   = 8;

  // Switching methods
  localparam logic [1:0] METHOD_BAND    = 2'h0;
  localparam logic [1:0] METHOD_LIMIT   = 2'h1;
  localparam logic [1:0] METHOD_CONTACT = 2'h2;

  // Reset values and scaling
  localparam logic [8:0]  RST_CTRL  = 9'h000;
  localparam pvsw_val_t   RST_RANGE = 16'h2710;
  localparam pvsw_val_t   RST_STEP  = 16'h000a;
  localparam pvsw_val_t   RST_ZERO  = 16'h0000;
  localparam pvsw_val_t   MV_FULL   = 16'h2710;
  localparam longint      HYST_NUM  = 5;
  localparam longint      HYST_DEN  = 1000;
  localparam int          BUMP_DECAY = 3;
  localparam int          LIN_PTS   = 11;

endpackage
